// [src/atx_regs.vh]
// Constants for the side-channel transmit insertion block.
// Assumes inclusion by bare name from the block's design files.
`ifndef ATX_REGS_VH
`define ATX_REGS_VH
// =====================================================================
// Frame geometry
// =====================================================================
`define ATX_WORD_W        32
`define ATX_BYTES         4
`define ATX_SEQ_W         7
`define ATX_SEQ_LAST      7'h03
`define ATX_X_LAST        8'hFF
`define ATX_Z_LAST        8'h95
`define ATX_BFN_LAST      12'hFFF
// =====================================================================
// Timing and buffering
// =====================================================================
`define ATX_EXTRA_LAT     4
`define ATX_FIFO_DEPTH    8
// Control byte mask of word zero of each basic frame (first byte only).
`define ATX_CTRL_W0       4'h8
`endif

// [src/atx_fifo.v]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
module atx_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             nrst,
    // Fill side.
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    // =================================================================
    // Storage and pointers
    // =================================================================
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word store.
    reg [AW-1:0]    wr_q;            // Write pointer.
    reg [AW-1:0]    rd_q;            // Read pointer.
    reg [AW:0]      cnt_q;           // Occupancy.
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update; a simultaneous push and pop keeps count.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Memory write, kept out of reset so it maps to plain RAM.
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule // atx_fifo

// [src/atx_insert.v]
// Transmit-side side-channel insertion port of a radio-link framer.
// Assumes clk is the link word clock and user logic shares it.
//
// Summary of operation
// RULE1: Word targets index shown latency cycles earlier.
// RULE2: User must present words at configured latency.
// RULE3: 32-bit words, top byte placed first.
// RULE4: Mask aligned with data and same latency.
// RULE5: Set mask bit forces supplied data bit.
// RULE6: User keeps mask clear where Z=X=0.
// RULE7: Mask over sync characters raises error next.
// RULE8: Drive one control flag per word byte.
// RULE9: Mask over control byte raises error next.
// RULE10: Master role: resync clears hyperframe, basic-frame.
// RULE11: One error bit per insertion word byte.
// RULE12: Resync acts on rising edge only.
// RULE13: Word index counts word positions per frame.
// RULE14: Cleared mask bits keep internal source data.
// The constants header must come first: the parameter defaults use its macros.
`include "atx_regs.vh"
module atx_insert #(
    parameter EXTRA_LAT = `ATX_EXTRA_LAT,
    parameter SEQ_LAST  = `ATX_SEQ_LAST
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        nrst,
    // Role and resync.
    input  wire        master_role,
    input  wire        frame_resync,
    // Insertion data from user logic.
    input  wire [31:0] side_tx_payload_in,
    input  wire [31:0] side_tx_bit_override,
    // Internal frame content source (normal transmit data).
    input  wire [31:0] int_frame_word,
    // Position outputs.
    output reg  [6:0]  word_index,
    output reg  [7:0]  basic_frame_index,
    output reg  [7:0]  hyperframe_num,
    output reg  [11:0] radio_frame_num,
    output reg  [3:0]  side_tx_control_slot_flags,
    // Errors and outgoing frame stream.
    output reg  [3:0]  overwrite_err,
    output reg  [31:0] frame_word_out,
    output reg         frame_word_valid,
    input  wire        frame_word_ready
);

    // =================================================================
    // Helper function
    // =================================================================
    // Bytes whose mask has any bit set; bit 3 is byte [31:24].
    function [3:0] byte_hit;
        input [31:0] m;
        begin
            byte_hit = {|m[31:24], |m[23:16], |m[15:8], |m[7:0]};
        end
    endfunction

    // Control bytes of a given word position; only word zero has one.
    function [3:0] ctrl_of;
        input [6:0] s;
        begin
            ctrl_of = (s == 7'h00) ? `ATX_CTRL_W0 : 4'h0;
        end
    endfunction

    // =================================================================
    // Resync edge detection
    // =================================================================
    // The resync pin comes from outside, so it is synchronised first.
    reg  rs_m_q;  // First stage, read only by the second.
    reg  rs_s_q;  // Second stage.
    reg  rs_p_q;  // Previous value for edge detection.
    wire rs_rise;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rs_m_q <= 1'b0;
            rs_s_q <= 1'b0;
            rs_p_q <= 1'b0;
        end else begin
            rs_m_q <= frame_resync;
            rs_s_q <= rs_m_q;
            rs_p_q <= rs_s_q;
        end
    end

    assign rs_rise = rs_s_q & ~rs_p_q & master_role; // [RULE12] [RULE10]

    // =================================================================
    // Frame position counters
    // =================================================================
    // Counters advance once per word; the stream stalls under back-pressure
    // so that no position is ever skipped.
    wire step;
    wire fifo_in_ready;
    assign step = fifo_in_ready;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_index        <= 7'h00;
            basic_frame_index <= 8'h00;
            hyperframe_num    <= 8'h00;
            radio_frame_num   <= 12'h000;
        end else if (rs_rise) begin
            // Restart numbering at the start of a hyperframe.
            word_index        <= 7'h00; // [RULE10]
            basic_frame_index <= 8'h00; // [RULE10]
            hyperframe_num    <= 8'h00; // [RULE10]
        end else if (step) begin
            if (word_index == SEQ_LAST[6:0]) begin // [RULE13]
                word_index <= 7'h00;
                if (basic_frame_index == `ATX_X_LAST) begin
                    basic_frame_index <= 8'h00;
                    if (hyperframe_num == `ATX_Z_LAST) begin
                        hyperframe_num  <= 8'h00;
                        radio_frame_num <= radio_frame_num + 12'h001;
                    end else begin
                        hyperframe_num <= hyperframe_num + 8'h01;
                    end
                end else begin
                    basic_frame_index <= basic_frame_index + 8'h01;
                end
            end else begin
                word_index <= word_index + 7'h01; // [RULE13]
            end
        end
    end

    // Control flags follow the word index in the same cycle.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Reset leaves the index at word zero, so its control byte shows.
            side_tx_control_slot_flags <= `ATX_CTRL_W0; // [RULE8]
        end else if (rs_rise) begin
            side_tx_control_slot_flags <= ctrl_of(7'h00); // [RULE8]
        end else if (step) begin
            side_tx_control_slot_flags <= ctrl_of((word_index == SEQ_LAST[6:0]) ?
                                                   7'h00 : word_index + 7'h01); // [RULE8]
        end
    end

    // =================================================================
    // Write latency pipeline
    // =================================================================
    // Delay position information by 1+EXTRA_LAT steps so it meets the
    // user's word. Stage 0 holds the index shown on the outputs one step earlier.
    localparam STG = EXTRA_LAT + 1;
    reg [3:0] ctl_pipe [0:STG-1]; // Control-byte flags in flight.
    reg       syn_pipe [0:STG-1]; // Sync-character position in flight.
    integer   i;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < STG; i = i + 1) begin
                ctl_pipe[i] <= 4'h0;
                syn_pipe[i] <= 1'b0;
            end
        end else if (step) begin
            ctl_pipe[0] <= side_tx_control_slot_flags; // [RULE1]
            syn_pipe[0] <= (hyperframe_num == 8'h00) && (basic_frame_index == 8'h00) &&
                           (word_index == 7'h00);
            for (i = 1; i < STG; i = i + 1) begin
                ctl_pipe[i] <= ctl_pipe[i-1]; // [RULE1] [RULE4]
                syn_pipe[i] <= syn_pipe[i-1];
            end
        end
    end

    // Flags that apply to the word presented this cycle.
    wire [3:0] cur_ctl;
    wire       cur_syn;
    assign cur_ctl = ctl_pipe[STG-1];
    assign cur_syn = syn_pipe[STG-1];

    // =================================================================
    // Merge and error detection
    // =================================================================
    // Mask bits replace internal bits; cleared bits keep the internal word.
    wire [31:0] merged;
    assign merged = (side_tx_payload_in & side_tx_bit_override) |
                    (int_frame_word & ~side_tx_bit_override); // [RULE5] [RULE14] [RULE4]

    // Error per byte, one cycle after the offending write. The user is
    // expected to clear the mask at sync positions; this only reports it.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overwrite_err <= 4'h0;
        end else if (step) begin
            overwrite_err <= byte_hit(side_tx_bit_override) &
                             (cur_ctl | {4{cur_syn}}); // [RULE9] [RULE7] [RULE11] [RULE6]
        end else begin
            overwrite_err <= 4'h0;
        end
    end

    // =================================================================
    // Outgoing buffer
    // =================================================================
    // Word bits [31:24] leave first; the serialiser downstream drains the
    // FIFO and its back-pressure stalls frame counting here.
    wire        f_valid;
    wire [31:0] f_data;

    atx_fifo #(
        .WIDTH (32),
        .DEPTH (`ATX_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (1'b1),
        .in_ready  (fifo_in_ready),
        .in_data   (merged), // [RULE3]
        .out_valid (f_valid),
        .out_ready (frame_word_ready | ~frame_word_valid),
        .out_data  (f_data)
    );

    // Register the FIFO head so the output comes straight from flops.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_word_out   <= 32'h00000000;
            frame_word_valid <= 1'b0;
        end else if (frame_word_ready | ~frame_word_valid) begin
            frame_word_out   <= f_data; // [RULE3]
            frame_word_valid <= f_valid;
        end
    end
endmodule // atx_insert

// [verification/atx_insert_checker.sv]
// Assertion checker for the side-channel insertion block.
// Assumes it is bound to atx_insert and sees only its ports.
module atx_insert_checker #(
    parameter int         EXTRA_LAT = 4,
    parameter logic [6:0] SEQ_LAST  = 7'h03
) (
    // Clock, reset and role.
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        master_role,
    input wire logic        frame_resync,
    // Mask and position.
    input wire logic [31:0] side_tx_bit_override,
    input wire logic [6:0]  word_index,
    input wire logic [7:0]  basic_frame_index,
    input wire logic [7:0]  hyperframe_num,
    input wire logic [3:0]  side_tx_control_slot_flags,
    // Errors and stream.
    input wire logic [3:0]  overwrite_err,
    input wire logic [31:0] frame_word_out,
    input wire logic        frame_word_valid,
    input wire logic        frame_word_ready
);
    // =====
    // Helpers
    // Bytes touched by the mask; an error bit may only follow one of these.
    wire [31:0] m = side_tx_bit_override;
    wire [3:0]  mb = {|m[31:24], |m[23:16], |m[15:8], |m[7:0]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // =====
    // Properties
    AST_SEQ_RANGE: assert property (word_index <= SEQ_LAST)
        else $error("word index out of range");
    AST_SEQ_STEP: assert property (word_index != $past(word_index) |-> word_index == 7'h00 ||
        word_index == $past(word_index) + 7'h01) else $error("word index skipped");
    AST_FLAGS: assert property (side_tx_control_slot_flags == ((word_index == 7'h00) ? 4'h8 : 4'h0))
        else $error("control slot flags wrong");
    AST_ERR_CAUSE: assert property ((overwrite_err & ~$past(mb)) == 4'h0)
        else $error("error on a byte the mask left clear");
    AST_ERR_PULSE: assert property (overwrite_err != 4'h0 |=> overwrite_err == 4'h0)
        else $error("error held too long");
    AST_X_STEP: assert property ($changed(basic_frame_index) |-> word_index == 7'h00)
        else $error("basic frame moved mid frame");
    AST_RESYNC: assert property (master_role && $rose(frame_resync) |-> ##[2:5]
        (word_index == 7'h00 && basic_frame_index == 8'h00 && hyperframe_num == 8'h00))
        else $error("resync did not clear numbering");
    AST_SLAVE_KEEP: assert property (!master_role && $rose(frame_resync) && basic_frame_index > 8'h02 &&
        basic_frame_index < 8'hF0 |-> ##5 basic_frame_index != 8'h00) else $error("slave resync acted");
    AST_OUT_HOLD: assert property (frame_word_valid && !frame_word_ready |=>
        frame_word_valid && $stable(frame_word_out)) else $error("output word dropped");
    cover property (overwrite_err == 4'h8);
    cover property (overwrite_err == 4'h1);
    cover property (frame_word_valid && !frame_word_ready);
endmodule // atx_insert_checker

bind atx_insert atx_insert_checker #(.EXTRA_LAT(EXTRA_LAT), .SEQ_LAST(SEQ_LAST)) u_chk (
    .clk(clk), .nrst(nrst), .master_role(master_role), .frame_resync(frame_resync),
    .side_tx_bit_override(side_tx_bit_override), .word_index(word_index),
    .basic_frame_index(basic_frame_index), .hyperframe_num(hyperframe_num),
    .side_tx_control_slot_flags(side_tx_control_slot_flags), .overwrite_err(overwrite_err),
    .frame_word_out(frame_word_out), .frame_word_valid(frame_word_valid),
    .frame_word_ready(frame_word_ready));

// [verification/atx_user_model.sv]
// User logic that writes one masked word into a chosen frame position.
// Assumes a free-running step each cycle while armed.
module atx_user_model #(
    parameter int LAT = 4
) (
    // Clock and frame position.
    input  wire logic        clk,
    input  wire logic [7:0]  pos,
    // Order from the bench.
    input  wire logic        arm,
    input  wire logic [7:0]  want,
    input  wire logic [31:0] m_in,
    input  wire logic [31:0] p_in,
    // Insertion port.
    output logic      [31:0] pay,
    output logic      [31:0] mask,
    output logic             fired
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] h [0:LAT]; // Position history, newest first.
    logic       done;
    initial begin
        pay = 32'h0;
        mask = 32'h0;
        fired = 1'b0;
        done = 1'b0;
    end
    // History of shown positions, so a word can be aimed 1+LAT cycles late.
    always @(posedge clk) begin
        h[0] <= pos;
        for (int i = 1; i <= LAT; i++)
            h[i] <= h[i-1];
    end
    // Idle data toggles so a stale word never looks valid.
    always @(negedge clk) begin
        fired <= 1'b0;
        mask <= 32'h0;
        pay <= ~pay;
        done <= arm & done;
        if (arm && !done && h[LAT] === want) begin
            mask <= m_in;
            pay <= p_in;
            fired <= 1'b1;
            done <= 1'b1;
        end
    end
endmodule // atx_user_model

// [verification/tb_atx_insert.sv]
// Self-checking bench for the side-channel insertion block.
// Assumes the default latency of four extra cycles.
module tb_atx_insert;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  w;
        logic [31:0] m, p, i;
        logic [3:0]  e;
    } atx_row_t;
    logic clk, nrst, master_role, frame_resync, rdy, arm, fired, vld;
    logic [31:0] pay, mask, iw, m_in, p_in, fout;
    logic [6:0] wi;
    logic [7:0] want, bfi, hfn;
    logic [3:0] flg, err;
    int n_mismatch = 0;
    int tests_run = 0;
    // Each row: {sync, word}, mask, payload, internal word, expected error.
    atx_row_t rows [5] = '{
        '{8'h01, 32'hFFFFFFFF, 32'h12345678, 32'hA5A5A5A5, 4'h0},
        '{8'h00, 32'hFF000000, 32'h3C000000, 32'hC3C3C3C3, 4'h8},
        '{8'h00, 32'h00FF00FF, 32'h12345678, 32'hA5A5A5A5, 4'h0},
        '{8'h03, 32'h0000F00F, 32'h0000ABCD, 32'h5A5A5A5A, 4'h0},
        '{8'h80, 32'h000000FF, 32'h000000EE, 32'h11111111, 4'h1}};
    atx_insert uut (.clk(clk), .nrst(nrst), .master_role(master_role), .frame_resync(frame_resync),
        .side_tx_payload_in(pay), .side_tx_bit_override(mask), .int_frame_word(iw), .word_index(wi),
        .basic_frame_index(bfi), .hyperframe_num(hfn), .radio_frame_num(),
        .side_tx_control_slot_flags(flg), .overwrite_err(err), .frame_word_out(fout),
        .frame_word_valid(vld), .frame_word_ready(rdy));
    atx_user_model #(.LAT(4)) u_user (.clk(clk), .pos({hfn == 8'h00 && bfi == 8'h00, wi}), .arm(arm),
        .want(want), .m_in(m_in), .p_in(p_in), .pay(pay), .mask(mask), .fired(fired));
    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Aims one word, then gathers errors and looks for the merged word.
    task automatic run_row(input atx_row_t r);
        logic [3:0] eo;
        logic       hit;
        eo = 4'h0;
        hit = 1'b0;
        {want, m_in, p_in, iw} = {r.w, r.m, r.p, r.i};
        frame_resync = r.w[7];
        repeat (3) @(negedge clk);
        frame_resync = 1'b0;
        arm = 1'b1;
        while (!fired) @(negedge clk);
        // The error pulse stands in the very cycle after the write, so look first.
        repeat (8) begin
            eo = eo | err;
            hit = hit | (vld && fout === ((r.p & r.m) | (r.i & ~r.m)));
            @(negedge clk);
        end
        arm = 1'b0;
        check(eo, r.e);
        check(hit, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A hang counts as a mismatch.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        {nrst, master_role, frame_resync, rdy, arm, iw, want, m_in, p_in} = {4'h4, 1'b0, 104'h0};
        rdy = 1'b1;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (40) @(negedge clk);
        foreach (rows[j]) begin
            run_row(rows[j]);
            $display("Row %0d done", j);
        end
        // A slave ignores resync.
        master_role = 1'b0;
        repeat (20) @(negedge clk);
        run_row('{8'h02, 32'h0, 32'h0, 32'h0, 4'h0});
        // Pulse resync as a slave: numbering must run on, two basic frames in eight cycles.
        want = bfi;
        frame_resync = 1'b1;
        repeat (8) @(negedge clk);
        frame_resync = 1'b0;
        check(bfi, want + 8'h02);
        $display("Slave resync done");
        // A full buffer freezes the position counters.
        rdy = 1'b0;
        repeat (20) @(negedge clk);
        want = {1'b0, wi};
        repeat (10) @(negedge clk);
        check({vld, 1'b0, wi}, {1'b1, want});
        rdy = 1'b1;
        repeat (20) @(negedge clk);
        $display("Stall done");
        nrst = 1'b0;
        @(negedge clk);
        check({wi, flg, err, vld}, 32'h00000100);
        $display("Reset done");
        complete_run();
    end
endmodule // tb_atx_insert
